// ===== inc/ppac_defines.vh
// register map, field positions and reset values of the pwm control block
`ifndef PPAC_DEFINES_VH
`define PPAC_DEFINES_VH
`define PPAC_OFS_PRCLK 4'h0
`define PPAC_OFS_CAE 4'h4
`define PPAC_OFS_CTL 4'h8
`define PPAC_OFS_CLK 4'hC
`define PPAC_OFS_SCLA 5'h10
`define PPAC_OFS_SCLB 5'h14
`define PPAC_OFS_STAT 5'h18
`define PPAC_ADDR_W 5
`define PPAC_PCKA_LSB 0
`define PPAC_PCKB_LSB 4
`define PPAC_JOIN_CH4_CH5_BIT 6
`define PPAC_JOIN_CH2_CH3_BIT 5
`define PPAC_JOIN_CH0_CH1_BIT 4
`define PPAC_SWAI_BIT 3
`define PPAC_FRZ_BIT 2
`define PPAC_PRCLK_MASK 8'h77
`define PPAC_CAE_MASK 8'h3F
`define PPAC_CTL_MASK 8'h7C
`define PPAC_CLK_MASK 8'h3F
`define PPAC_RST_8 8'h00
`define PPAC_RESP_OKAY 2'h0
`define PPAC_RESP_SLVERR 2'h2
`endif

// ===== rtl/ppac_scaler.v
// scaled clock enable generator: divides an input enable by twice a scale value
`timescale 1ns/1ns
`default_nettype none
module ppac_scaler (
	input wire MCLK,
	input wire RESETN,
	input wire in_pulse,
	input wire [7:0] scale,
	input wire reload,
	output reg out_pulse
);
	reg [8:0] cnt_reg;
	reg half_reg;
	wire [8:0] full = (scale == 8'h00) ? 9'h100 : {1'b0, scale};
	always @(posedge MCLK) begin
		if (!RESETN) begin
			cnt_reg <= 9'h001;
			half_reg <= 1'b0;
			out_pulse <= 1'b0;
		end else if (reload) begin
			cnt_reg <= full;
			half_reg <= 1'b0;
			out_pulse <= 1'b0;
		end else begin
			out_pulse <= 1'b0;
			if (in_pulse) begin
				if (cnt_reg <= 9'h001) begin
					cnt_reg <= full;
					half_reg <= ~half_reg;
					out_pulse <= half_reg;
				end else begin
					cnt_reg <= cnt_reg - 9'h001;
				end
			end
		end
	end
endmodule // ppac_scaler
`default_nettype wire

// ===== rtl/ppac_ctrl.v
// pwm prescaler, alignment and pairing control with an axi4-lite register slave
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "ppac_defines.vh"
module ppac_ctrl (
	input wire MCLK,
	input wire RESETN,
	input wire WAIT_MODE,
	input wire FREEZE_MODE,
	input wire [5:0] CHANNEL_START_LEVEL,
	input wire [5:0] CHANNEL_ENABLE_BIT,
	input wire [5:0] RAW_WAVE,
	input wire [`PPAC_ADDR_W-1:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output wire S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output wire S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [`PPAC_ADDR_W-1:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output wire S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	output reg CLK_A_EN,
	output reg CLK_B_EN,
	output reg CLK_SA_EN,
	output reg CLK_SB_EN,
	output reg [5:0] CHANNEL_TICK,
	output reg [5:0] CENTER_MODE_BIT,
	output reg JOIN_CH4_CH5,
	output reg JOIN_CH2_CH3,
	output reg JOIN_CH0_CH1,
	output reg [5:0] CHANNEL_RUN,
	output reg [5:0] WAVEFORM_OUTPUT_PORT
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [7:0] prclk_reg;
	reg [7:0] cae_reg;
	reg [7:0] ctl_reg;
	reg [7:0] clksel_reg;
	reg [7:0] scla_reg;
	reg [7:0] sclb_reg;
	reg [6:0] pre_reg;
	reg [6:0] pre_next;
	reg [2:0] wait_s_reg;
	reg [2:0] frz_s_reg;
	reg wait_reg;
	reg frz_reg;
	reg [`PPAC_ADDR_W-1:0] awaddr_reg;
	reg aw_full_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg w_full_reg;
	reg scla_wr_reg;
	reg sclb_wr_reg;
	wire [2:0] sel_a = prclk_reg[`PPAC_PCKA_LSB+2:`PPAC_PCKA_LSB];
	wire [2:0] sel_b = prclk_reg[`PPAC_PCKB_LSB+2:`PPAC_PCKB_LSB];
	wire stop_in_wait = ctl_reg[`PPAC_SWAI_BIT];
	wire stop_in_freeze = ctl_reg[`PPAC_FRZ_BIT];
	wire pre_run = !((stop_in_wait && wait_reg) || (stop_in_freeze && frz_reg));
	wire sa_pulse;
	wire sb_pulse;
	// ----------------------------------------
	// mode input synchronisers
	// ----------------------------------------
	always @(posedge MCLK) begin
		if (!RESETN) begin
			wait_s_reg <= 3'h0;
			frz_s_reg <= 3'h0;
			wait_reg <= 1'b0;
			frz_reg <= 1'b0;
		end else begin
			wait_s_reg <= {wait_s_reg[1:0], WAIT_MODE};
			frz_s_reg <= {frz_s_reg[1:0], FREEZE_MODE};
			if (wait_s_reg[2] == wait_s_reg[1])
				wait_reg <= wait_s_reg[2];
			if (frz_s_reg[2] == frz_s_reg[1])
				frz_reg <= frz_s_reg[2];
		end
	end
	// ----------------------------------------
	// prescaler
	// ----------------------------------------
	always @* begin
		pre_next = pre_run ? pre_reg + 7'h01 : pre_reg;
	end
	function div_tick;
		input [2:0] sel;
		input [6:0] cnt;
		reg [6:0] mask;
		begin
			mask = 7'h7F >> (3'd7 - sel);
			div_tick = ((cnt & mask) == mask);
		end
	endfunction
	always @(posedge MCLK) begin
		if (!RESETN) begin
			pre_reg <= 7'h00;
			CLK_A_EN <= 1'b0;
			CLK_B_EN <= 1'b0;
		end else begin
			pre_reg <= pre_next;
			CLK_A_EN <= pre_run && div_tick(sel_a, pre_reg);
			CLK_B_EN <= pre_run && div_tick(sel_b, pre_reg);
		end
	end
	ppac_scaler u_scl_a (
		.MCLK(MCLK),
		.RESETN(RESETN),
		.in_pulse(CLK_A_EN),
		.scale(scla_reg),
		.reload(scla_wr_reg),
		.out_pulse(sa_pulse)
	);
	ppac_scaler u_scl_b (
		.MCLK(MCLK),
		.RESETN(RESETN),
		.in_pulse(CLK_B_EN),
		.scale(sclb_reg),
		.reload(sclb_wr_reg),
		.out_pulse(sb_pulse)
	);
	// ----------------------------------------
	// per-channel outputs
	// ----------------------------------------
	wire [5:0] join_low = {ctl_reg[`PPAC_JOIN_CH4_CH5_BIT], 1'b0, ctl_reg[`PPAC_JOIN_CH2_CH3_BIT],
		1'b0, ctl_reg[`PPAC_JOIN_CH0_CH1_BIT], 1'b0};
	wire [5:0] join_high = {1'b0, ctl_reg[`PPAC_JOIN_CH4_CH5_BIT], 1'b0,
		ctl_reg[`PPAC_JOIN_CH2_CH3_BIT], 1'b0, ctl_reg[`PPAC_JOIN_CH0_CH1_BIT]};
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_ch
			wire use_b = (gi == 2) || (gi == 3);
			wire plain = use_b ? CLK_B_EN : CLK_A_EN;
			wire scaled = use_b ? sb_pulse : sa_pulse;
			always @(posedge MCLK) begin
				if (!RESETN) begin
					CHANNEL_TICK[gi] <= 1'b0;
					CENTER_MODE_BIT[gi] <= 1'b0;
					CHANNEL_RUN[gi] <= 1'b0;
					WAVEFORM_OUTPUT_PORT[gi] <= 1'b0;
				end else begin
					CHANNEL_TICK[gi] <= clksel_reg[gi] ? scaled : plain;
					CENTER_MODE_BIT[gi] <= cae_reg[gi];
					CHANNEL_RUN[gi] <= CHANNEL_ENABLE_BIT[gi] && !join_high[gi];
					if (join_high[gi])
						WAVEFORM_OUTPUT_PORT[gi] <= 1'b0;
					else if (!CHANNEL_ENABLE_BIT[gi])
						WAVEFORM_OUTPUT_PORT[gi] <= CHANNEL_START_LEVEL[gi];
					else
						WAVEFORM_OUTPUT_PORT[gi] <= RAW_WAVE[gi] ^ CHANNEL_START_LEVEL[gi];
				end
			end
		end
	endgenerate
	always @(posedge MCLK) begin
		if (!RESETN) begin
			JOIN_CH4_CH5 <= 1'b0;
			JOIN_CH2_CH3 <= 1'b0;
			JOIN_CH0_CH1 <= 1'b0;
			CLK_SA_EN <= 1'b0;
			CLK_SB_EN <= 1'b0;
		end else begin
			CLK_SA_EN <= sa_pulse;
			CLK_SB_EN <= sb_pulse;
			JOIN_CH4_CH5 <= join_low[5];
			JOIN_CH2_CH3 <= join_low[3];
			JOIN_CH0_CH1 <= join_low[1];
		end
	end
	// ----------------------------------------
	// axi4-lite write
	// ----------------------------------------
	assign S_AXI_AWREADY = !aw_full_reg && !S_AXI_BVALID;
	assign S_AXI_WREADY = !w_full_reg && !S_AXI_BVALID;
	wire do_write = aw_full_reg && w_full_reg && !S_AXI_BVALID;
	wire [`PPAC_ADDR_W-1:0] wa = {awaddr_reg[`PPAC_ADDR_W-1:2], 2'b00};
	wire wr_lane = wstrb_reg[0];
	wire [7:0] wd = wdata_reg[7:0];
	always @(posedge MCLK) begin
		if (!RESETN) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awaddr_reg <= {`PPAC_ADDR_W{1'b0}};
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `PPAC_RESP_OKAY;
			prclk_reg <= `PPAC_RST_8;
			cae_reg <= `PPAC_RST_8;
			ctl_reg <= `PPAC_RST_8;
			clksel_reg <= `PPAC_RST_8;
			scla_reg <= `PPAC_RST_8;
			sclb_reg <= `PPAC_RST_8;
			scla_wr_reg <= 1'b0;
			sclb_wr_reg <= 1'b0;
		end else begin
			scla_wr_reg <= 1'b0;
			sclb_wr_reg <= 1'b0;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				awaddr_reg <= S_AXI_AWADDR;
				aw_full_reg <= 1'b1;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				wdata_reg <= S_AXI_WDATA;
				wstrb_reg <= S_AXI_WSTRB;
				w_full_reg <= 1'b1;
			end
			if (do_write) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= `PPAC_RESP_OKAY;
				case (wa)
					{1'b0, `PPAC_OFS_PRCLK}: if (wr_lane) prclk_reg <= wd & `PPAC_PRCLK_MASK;
					{1'b0, `PPAC_OFS_CAE}: if (wr_lane) cae_reg <= wd & `PPAC_CAE_MASK;
					{1'b0, `PPAC_OFS_CTL}: if (wr_lane) ctl_reg <= wd & `PPAC_CTL_MASK;
					{1'b0, `PPAC_OFS_CLK}: if (wr_lane) clksel_reg <= wd & `PPAC_CLK_MASK;
					`PPAC_OFS_SCLA: if (wr_lane) begin
						scla_reg <= wd;
						scla_wr_reg <= 1'b1;
					end
					`PPAC_OFS_SCLB: if (wr_lane) begin
						sclb_reg <= wd;
						sclb_wr_reg <= 1'b1;
					end
					`PPAC_OFS_STAT: S_AXI_BRESP <= `PPAC_RESP_OKAY;
					default: S_AXI_BRESP <= `PPAC_RESP_SLVERR;
				endcase
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// axi4-lite read
	// ----------------------------------------
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	wire [`PPAC_ADDR_W-1:0] ra = {S_AXI_ARADDR[`PPAC_ADDR_W-1:2], 2'b00};
	always @(posedge MCLK) begin
		if (!RESETN) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `PPAC_RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= `PPAC_RESP_OKAY;
			case (ra)
				{1'b0, `PPAC_OFS_PRCLK}: S_AXI_RDATA <= {24'h000000, prclk_reg};
				{1'b0, `PPAC_OFS_CAE}: S_AXI_RDATA <= {24'h000000, cae_reg};
				{1'b0, `PPAC_OFS_CTL}: S_AXI_RDATA <= {24'h000000, ctl_reg};
				{1'b0, `PPAC_OFS_CLK}: S_AXI_RDATA <= {24'h000000, clksel_reg};
				`PPAC_OFS_SCLA: S_AXI_RDATA <= {24'h000000, scla_reg};
				`PPAC_OFS_SCLB: S_AXI_RDATA <= {24'h000000, sclb_reg};
				`PPAC_OFS_STAT: S_AXI_RDATA <= {22'h000000, pre_reg, frz_reg, wait_reg, pre_run};
				default: begin
					S_AXI_RDATA <= 32'h00000000;
					S_AXI_RRESP <= `PPAC_RESP_SLVERR;
				end
			endcase
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end
endmodule // ppac_ctrl
`default_nettype wire

// ===== test/ppac_checker.sv
// concurrent checks on the pwm control block ports
`timescale 1ns/1ns
`default_nettype none
module ppac_checker (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic [5:0] CHANNEL_START_LEVEL,
	input wire logic [5:0] CHANNEL_ENABLE_BIT,
	input wire logic [5:0] RAW_WAVE,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic CLK_A_EN,
	input wire logic JOIN_CH4_CH5,
	input wire logic JOIN_CH2_CH3,
	input wire logic JOIN_CH0_CH1,
	input wire logic [5:0] CHANNEL_RUN,
	input wire logic [5:0] WAVEFORM_OUTPUT_PORT
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	a_join01_off: assert property (JOIN_CH0_CH1 [*3] |-> !CHANNEL_RUN[0] && !WAVEFORM_OUTPUT_PORT[0])
		else $error("channel 0 live while joined");
	a_join23_off: assert property (JOIN_CH2_CH3 [*3] |-> !CHANNEL_RUN[2] && !WAVEFORM_OUTPUT_PORT[2])
		else $error("channel 2 live while joined");
	a_join45_off: assert property (JOIN_CH4_CH5 [*3] |-> !CHANNEL_RUN[4] && !WAVEFORM_OUTPUT_PORT[4])
		else $error("channel 4 live while joined");
	a_idle_level: assert property (!CHANNEL_ENABLE_BIT[3] |=> WAVEFORM_OUTPUT_PORT[3] == $past(CHANNEL_START_LEVEL[3]))
		else $error("disabled pin not at start level");
	a_drive_level: assert property (CHANNEL_ENABLE_BIT[3] |=> WAVEFORM_OUTPUT_PORT[3] == ($past(CHANNEL_START_LEVEL[3]) ^ $past(RAW_WAVE[3])))
		else $error("driven pin level wrong");
	a_bresp_clear: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("write response repeated");
	a_rdata_clear: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
		else $error("read response repeated");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read not answered next cycle");
	cover property (JOIN_CH0_CH1 && CHANNEL_ENABLE_BIT[1]);
	cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
	cover property (CLK_A_EN ##1 !CLK_A_EN);
endmodule // ppac_checker
`default_nettype wire

// ===== test/ppac_load.sv
// load on the waveform pins: counts rising edges on pin 0
`timescale 1ns/1ns
`default_nettype none
module ppac_load (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic [5:0] PINS,
	output logic [7:0] rises0
);
	logic last;
	always @(posedge MCLK) begin
		if (!RESETN) begin
			rises0 <= 8'h00;
			last <= 1'b0;
		end else begin
			last <= PINS[0];
			if (PINS[0] && !last) rises0 <= rises0 + 8'h01;
		end
	end
endmodule // ppac_load
`default_nettype wire

// ===== test/ppac_ctrl_tb_top.sv
// self-checking bench for the pwm control block
`timescale 1ns/1ns
`default_nettype none
`include "ppac_defines.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module ppac_ctrl_tb_top;
	logic MCLK = 0, RESETN = 0, WAIT_MODE = 0, FREEZE_MODE = 0;
	logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
	logic [5:0] CHANNEL_START_LEVEL = 0, CHANNEL_ENABLE_BIT = 0, RAW_WAVE = 0;
	logic [4:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
	logic [31:0] S_AXI_WDATA = 0;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, CLK_A_EN, CLK_B_EN;
	wire CLK_SA_EN, CLK_SB_EN;
	wire JOIN_CH4_CH5, JOIN_CH2_CH3, JOIN_CH0_CH1;
	wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
	wire [31:0] S_AXI_RDATA;
	wire [5:0] CHANNEL_TICK, CENTER_MODE_BIT, CHANNEL_RUN, WAVEFORM_OUTPUT_PORT;
	wire [7:0] rises0;
	int mismatches = 0, cmp_count = 0, cyc = 0, na, nb, i, ns, nt0, nt1, nt3;
	logic [31:0] d;
	logic [1:0] r;
	logic [4:0] ra[7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h1C};
	logic [7:0] rw[7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h5A, 8'h00, 8'h12};
	logic [7:0] re[7] = '{8'h77, 8'h3F, 8'h7C, 8'h3F, 8'h5A, 8'h00, 8'h00};
	logic [7:0] fc[5] = '{8'h04, 8'h00, 8'h04, 8'h08, 8'h00};
	logic [1:0] fm[5] = '{2'b10, 2'b10, 2'b00, 2'b01, 2'b01};
	int fe[5] = '{0, 64, 64, 0, 64};
	ppac_ctrl uut (.MCLK, .RESETN, .WAIT_MODE, .FREEZE_MODE, .CHANNEL_START_LEVEL, .CHANNEL_ENABLE_BIT,
		.RAW_WAVE, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
		.S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
		.S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
		.CLK_A_EN, .CLK_B_EN, .CLK_SA_EN, .CLK_SB_EN, .CHANNEL_TICK, .CENTER_MODE_BIT,
		.JOIN_CH4_CH5, .JOIN_CH2_CH3, .JOIN_CH0_CH1, .CHANNEL_RUN, .WAVEFORM_OUTPUT_PORT);
	ppac_load load (.MCLK, .RESETN, .PINS(WAVEFORM_OUTPUT_PORT), .rises0);
	always #50 MCLK = ~MCLK;
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 10000) begin
			mismatches++;
			wrap_up;
		end
	end
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge MCLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= {24'h000000, v};
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while (S_AXI_BVALID !== 1'b1);
		r = S_AXI_BRESP;
		S_AXI_BREADY <= 1'b0;
	endtask
	task rd(input logic [4:0] a);
		@(posedge MCLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
		end while (S_AXI_RVALID !== 1'b1);
		d = S_AXI_RDATA;
		r = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
	endtask
	task cnt(input int n);
		na = 0;
		nb = 0;
		ns = 0;
		nt0 = 0;
		nt1 = 0;
		nt3 = 0;
		repeat (4) @(posedge MCLK);
		repeat (n) begin
			@(posedge MCLK);
			na += int'(CLK_A_EN === 1'b1);
			nb += int'(CLK_B_EN === 1'b1);
			ns += int'(CLK_SA_EN === 1'b1);
			nt0 += int'(CHANNEL_TICK[0] === 1'b1);
			nt1 += int'(CHANNEL_TICK[1] === 1'b1);
			nt3 += int'(CHANNEL_TICK[3] === 1'b1);
		end
	endtask
	task wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge MCLK);
		RESETN <= 1'b1;
		for (i = 0; i < 7; i++) begin
			rd(ra[i]);
			`CHK(d, 32'h00000000)
			wr(ra[i], rw[i]);
			`CHK(r, (i == 6) ? 2'h2 : 2'h0)
			rd(ra[i]);
			`CHK(d, {24'h000000, re[i]})
			`CHK(r, (i == 6) ? 2'h2 : 2'h0)
		end
		for (i = 0; i < 8; i++) begin
			wr(`PPAC_OFS_CTL, 8'h00);
			wr(`PPAC_OFS_PRCLK, {1'b0, 3'(7 - i), 1'b0, 3'(i)});
			cnt(256);
			`CHK(na, 256 >> i)
			`CHK(nb, 256 >> (7 - i))
		end
		wr(`PPAC_OFS_PRCLK, 8'h00);
		for (i = 0; i < 5; i++) begin
			{FREEZE_MODE, WAIT_MODE} <= fm[i];
			wr(`PPAC_OFS_CTL, fc[i]);
			repeat (4) @(posedge MCLK);
			cnt(64);
			`CHK(na, fe[i])
			rd(`PPAC_OFS_STAT);
			`CHK(d[2:0], {fm[i], fe[i] != 0})
		end
		{FREEZE_MODE, WAIT_MODE} <= 2'b00;
		wr(`PPAC_OFS_SCLA, 8'h02);
		wr(`PPAC_OFS_SCLB, 8'h01);
		wr(`PPAC_OFS_CLK, 8'h09);
		cnt(256);
		`CHK(ns, 64)
		`CHK(nt0, 64)
		`CHK(nt1, 256)
		`CHK(nt3, 128)
		wr(`PPAC_OFS_CAE, 8'h2A);
		wr(`PPAC_OFS_CTL, 8'h70);
		CHANNEL_START_LEVEL <= 6'h3F;
		CHANNEL_ENABLE_BIT <= 6'h3F;
		repeat (3) @(posedge MCLK);
		`CHK(CENTER_MODE_BIT, 6'h2A)
		`CHK({JOIN_CH4_CH5, JOIN_CH2_CH3, JOIN_CH0_CH1}, 3'h7)
		`CHK(CHANNEL_RUN, 6'h2A)
		`CHK(WAVEFORM_OUTPUT_PORT, 6'h2A)
		CHANNEL_ENABLE_BIT <= 6'h00;
		wr(`PPAC_OFS_CTL, 8'h00);
		CHANNEL_ENABLE_BIT <= 6'h3F;
		RAW_WAVE <= 6'h08;
		repeat (3) @(posedge MCLK);
		`CHK(CHANNEL_RUN, 6'h3F)
		`CHK(WAVEFORM_OUTPUT_PORT, 6'h37)
		`CHK(rises0, 8'h01)
		RESETN <= 1'b0;
		repeat (3) @(posedge MCLK);
		RESETN <= 1'b1;
		rd(`PPAC_OFS_CAE);
		`CHK(d, 32'h00000000)
		`CHK(CENTER_MODE_BIT, 6'h00)
		`CHK(CHANNEL_RUN, 6'h3F)
		wrap_up;
	end
endmodule // ppac_ctrl_tb_top
bind ppac_ctrl ppac_checker chk (.MCLK, .RESETN, .CHANNEL_START_LEVEL, .CHANNEL_ENABLE_BIT, .RAW_WAVE,
	.S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_RVALID,
	.S_AXI_RREADY,
	.CLK_A_EN, .JOIN_CH4_CH5, .JOIN_CH2_CH3, .JOIN_CH0_CH1, .CHANNEL_RUN, .WAVEFORM_OUTPUT_PORT);
`default_nettype wire
